//--- hdl/pint_map.vh
// Purpose: constants for the program interrupt unit
// Assumes: word-wide register port, byte offsets
// Notes: class numbers double as dispatch priority, lowest first
`ifndef PINT_MAP_VH
`define PINT_MAP_VH

// Class numbers
`define CLS_ERROR       3'h0
`define CLS_DISC        3'h1
`define CLS_INPUT       3'h2
`define CLS_REALTIME    3'h3
`define CLS_UNITREC     3'h4
`define CLS_OTHERCPU    3'h5
`define CLS_COUNT       6

// Error class detail positions
`define ERR_XFER_PAR    0
`define ERR_ARITH_CHAR  1
`define ERR_ADDR        2
`define ERR_PROGRAM     3
`define ERR_DISC_PAR    4
`define ERR_IO_PAR      5
`define ERR_UR_PAR      6
`define ERR_COMPUTER_LO 0
`define ERR_COMPUTER_HI 3
`define ERR_IFACE_LO    4
`define ERR_IFACE_HI    7

// Register offsets
`define OFS_CONTROL     8'h00
`define OFS_CLASS_IGN   8'h04
`define OFS_SUB_IGN     8'h08
`define OFS_STATUS      8'h0C
`define OFS_COMMAND     8'h10
`define OFS_DETAIL_BASE 8'h20

// Control fields
`define CTL_GLOBAL_IGN  0
`define CTL_OVERRIDE    1
`define SUB_COMPUTER    0
`define SUB_IFACE       1

// Command fields and operations
`define CMD_CLASS_LO    0
`define CMD_DETAIL_LO   8
`define CMD_OP_LO       12
`define CMD_RESUME      15
`define OP_NONE         2'h0
`define OP_SET_ONE      2'h1
`define OP_CLR_ONE      2'h2
`define OP_CLR_CLASS    2'h3

// Status fields
`define STS_CLASS_LO    0
`define STS_BUSY        3
`define STS_PEND_LO     8

// Reset values
`define RST_CONTROL     2'h0
`define RST_CLASS_IGN   6'h00
`define RST_SUB_IGN     2'h0

`endif

//--- hdl/request_bank.v
// Purpose: storage toggles for the detail requests of one class
// Assumes: set inputs are single-cycle pulses on sys_clk
// Notes: any set beats any clear in the same cycle
`timescale 1ns/1ps

module request_bank #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             rst_n,
    // Sources
    input  wire [WIDTH-1:0] hw_set,
    input  wire [WIDTH-1:0] sw_set,
    input  wire [WIDTH-1:0] sw_clr,
    // State
    output reg  [WIDTH-1:0] toggles
);

reg [WIDTH-1:0] next_toggles;

always @* begin
    next_toggles = (toggles & ~sw_clr) | hw_set | sw_set;
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        toggles <= {WIDTH{1'b0}};
    end else begin
        toggles <= next_toggles;
    end
end

endmodule

//--- hdl/program_interrupt_unit.v
// Purpose: request collection, ignore control and class dispatch
// Assumes: event inputs are pulses from logic on sys_clk
// Notes: one class handled at a time; resume re-arms dispatch
`timescale 1ns/1ps
`include "pint_map.vh"

// Functional notes
// - Six classes, each with own entry
// - Error, disc, input, realtime, unitrecord, othercpu
// - Every detail toggle readable by software
// - Error class: computer and interface divisions
// - Toggles set, cleared singly or by class
// - Ignore by class, subclass, globally; keep stored
// - Transfer completion sets interface class request
// - Input message ready raises input request
// - Far-end parity error raises interface error
// - Stop transfer on far-end parity error unless override
// - Sensed error interrupts unless ignored
// - Take jumps to class entry, resumable
// - Illegal operand or address characters are errors
// - Missing memory module flags error
// - Character parity checked on every transfer
module program_interrupt_unit #(
    parameter DETAIL     = 8,
    parameter CHAR_W     = 6,
    parameter ENTRY_W    = 16,
    parameter ENTRY_BASE = 16'h0100,
    parameter ENTRY_STEP = 16'h0010
) (
    // Clock and reset
    input  wire                sys_clk,
    input  wire                resetn,
    // Register port
    input  wire [7:0]          reg_addr,
    input  wire [31:0]         reg_wdata,
    input  wire                reg_wr,
    input  wire                reg_rd,
    output reg  [31:0]         reg_rdata,
    // Processor error checks
    input  wire                xfer_valid,
    input  wire [CHAR_W-1:0]   xfer_char,
    input  wire                xfer_parity,
    input  wire                arith_bad_char,
    input  wire                addr_bad_char,
    input  wire                module_missing,
    input  wire                program_fault,
    // Interface far-end parity errors
    input  wire                disc_par_err,
    input  wire                io_par_err,
    input  wire                ur_par_err,
    // Completion and message events per class
    input  wire [DETAIL-1:0]   disc_evt,
    input  wire [DETAIL-1:0]   input_evt,
    input  wire [DETAIL-1:0]   realtime_evt,
    input  wire [DETAIL-1:0]   unitrec_evt,
    input  wire [DETAIL-1:0]   othercpu_evt,
    // Program control side
    input  wire                handler_done,
    output reg                 take,
    output reg  [ENTRY_W-1:0]  entry_addr,
    output reg  [2:0]          active_class,
    output reg                 busy,
    // Transfer stop requests
    output reg                 disc_stop,
    output reg                 io_stop,
    output reg                 ur_stop
);

localparam NCLS = `CLS_COUNT;

// Dispatch states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_TAKE = 3'b010;
localparam [2:0] ST_HAND = 3'b100;

////////////////////////////////////////////////////////////////////////////////

function [DETAIL-1:0] onehot;
    input [2:0] idx;
    integer k;
    begin
        onehot = {DETAIL{1'b0}};
        for (k = 0; k < DETAIL; k = k + 1) begin
            if (idx == k[2:0]) begin
                onehot[k] = 1'b1;
            end
        end
    end
endfunction

function [2:0] first_set;
    input [NCLS-1:0] vec;
    integer k;
    begin
        first_set = 3'h0;
        for (k = NCLS - 1; k >= 0; k = k - 1) begin
            if (vec[k]) begin
                first_set = k[2:0];
            end
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Reset release

reg rst_meta;
reg rst_n;

always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
        rst_meta <= 1'b0;
        rst_n    <= 1'b0;
    end else begin
        rst_meta <= 1'b1;
        rst_n    <= rst_meta;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Software controls

reg  [1:0]      control;
reg  [NCLS-1:0] class_ign;
reg  [1:0]      sub_ign;
wire            wr_cmd;
wire [1:0]      cmd_op;
wire [2:0]      cmd_class;
wire [2:0]      cmd_detail;
wire            cmd_resume;

assign wr_cmd     = reg_wr && (reg_addr == `OFS_COMMAND);
assign cmd_op     = reg_wdata[`CMD_OP_LO +: 2];
assign cmd_class  = reg_wdata[`CMD_CLASS_LO +: 3];
assign cmd_detail = reg_wdata[`CMD_DETAIL_LO +: 3];
assign cmd_resume = wr_cmd && reg_wdata[`CMD_RESUME];

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        control   <= `RST_CONTROL;
        class_ign <= `RST_CLASS_IGN;
        sub_ign   <= `RST_SUB_IGN;
    end else if (reg_wr) begin
        case (reg_addr)
            `OFS_CONTROL: begin
                control <= reg_wdata[1:0];
            end
            `OFS_CLASS_IGN: begin
                class_ign <= reg_wdata[NCLS-1:0];
            end
            `OFS_SUB_IGN: begin
                sub_ign <= reg_wdata[1:0];
            end
            default: begin
                control <= control;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Error detection

reg  [DETAIL-1:0] err_set;
wire              par_bad;

assign par_bad = xfer_valid && ~(^{xfer_char, xfer_parity});

always @* begin
    err_set = {DETAIL{1'b0}};
    err_set[`ERR_XFER_PAR] = par_bad;
    err_set[`ERR_ARITH_CHAR] = arith_bad_char;
    err_set[`ERR_ADDR] = addr_bad_char | module_missing;
    err_set[`ERR_PROGRAM] = program_fault;
    err_set[`ERR_DISC_PAR] = disc_par_err;
    err_set[`ERR_IO_PAR] = io_par_err;
    err_set[`ERR_UR_PAR] = ur_par_err;
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        disc_stop <= 1'b0;
        io_stop   <= 1'b0;
        ur_stop   <= 1'b0;
    end else begin
        disc_stop <= disc_par_err & ~control[`CTL_OVERRIDE];
        io_stop   <= io_par_err & ~control[`CTL_OVERRIDE];
        ur_stop   <= ur_par_err & ~control[`CTL_OVERRIDE];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Request toggles

wire [DETAIL*NCLS-1:0] hw_set;
wire [DETAIL*NCLS-1:0] toggles;

assign hw_set = {othercpu_evt, unitrec_evt, realtime_evt,
                 input_evt, disc_evt, err_set};

genvar c;
generate
    for (c = 0; c < NCLS; c = c + 1) begin : g_cls
        wire            hit;
        wire [DETAIL-1:0] sw_set;
        wire [DETAIL-1:0] sw_clr;
        assign hit    = wr_cmd && (cmd_class == c);
        assign sw_set = (hit && cmd_op == `OP_SET_ONE) ?
                        onehot(cmd_detail) : {DETAIL{1'b0}};
        assign sw_clr = (hit && cmd_op == `OP_CLR_ONE) ? onehot(cmd_detail) :
                        (hit && cmd_op == `OP_CLR_CLASS) ? {DETAIL{1'b1}} :
                        {DETAIL{1'b0}};
        request_bank #(
            .WIDTH (DETAIL)
        ) u_bank (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .hw_set  (hw_set[c*DETAIL +: DETAIL]),
            .sw_set  (sw_set),
            .sw_clr  (sw_clr),
            .toggles (toggles[c*DETAIL +: DETAIL])
        );
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Ignore gating

reg  [DETAIL-1:0] err_mask;
reg  [NCLS-1:0]   pending;
integer           n;

always @* begin
    err_mask = {DETAIL{1'b1}};
    if (sub_ign[`SUB_COMPUTER]) begin
        err_mask[`ERR_COMPUTER_HI:`ERR_COMPUTER_LO] = 4'h0;
    end
    if (sub_ign[`SUB_IFACE]) begin
        err_mask[`ERR_IFACE_HI:`ERR_IFACE_LO] = 4'h0;
    end
    pending[0] = |(toggles[DETAIL-1:0] & err_mask);
    for (n = 1; n < NCLS; n = n + 1) begin
        pending[n] = |toggles[n*DETAIL +: DETAIL];
    end
    pending = pending & ~class_ign & {NCLS{~control[`CTL_GLOBAL_IGN]}};
end

////////////////////////////////////////////////////////////////////////////////
// Dispatch

reg [2:0] state;
reg [2:0] next_state;
wire      any_pend;
wire [2:0] win;

assign any_pend = |pending;
assign win = first_set(pending);

always @* begin
    case (state)
        ST_IDLE: begin
            next_state = any_pend ? ST_TAKE : ST_IDLE;
        end
        ST_TAKE: begin
            next_state = ST_HAND;
        end
        ST_HAND: begin
            next_state = (handler_done || cmd_resume) ? ST_IDLE : ST_HAND;
        end
        default: begin
            next_state = ST_IDLE;
        end
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        state        <= ST_IDLE;
        take         <= 1'b0;
        busy         <= 1'b0;
        active_class <= 3'h0;
        entry_addr   <= {ENTRY_W{1'b0}};
    end else begin
        state <= next_state;
        take  <= 1'b0;
        if (state == ST_IDLE && any_pend) begin
            active_class <= win;
            entry_addr   <= ENTRY_BASE + ENTRY_STEP * {{(ENTRY_W-3){1'b0}}, win};
            take         <= 1'b1;
            busy         <= 1'b1;
        end else if (next_state == ST_IDLE) begin
            busy <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read port

reg [31:0] next_rdata;
integer    r;

always @* begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
        `OFS_CONTROL: begin
            next_rdata[1:0] = control;
        end
        `OFS_CLASS_IGN: begin
            next_rdata[NCLS-1:0] = class_ign;
        end
        `OFS_SUB_IGN: begin
            next_rdata[1:0] = sub_ign;
        end
        `OFS_STATUS: begin
            next_rdata[`STS_CLASS_LO +: 3] = active_class;
            next_rdata[`STS_BUSY] = busy;
            next_rdata[`STS_PEND_LO +: NCLS] = pending;
        end
        default: begin
            for (r = 0; r < NCLS; r = r + 1) begin
                if (reg_addr == `OFS_DETAIL_BASE + 4 * r) begin
                    next_rdata[DETAIL-1:0] = toggles[r*DETAIL +: DETAIL];
                end
            end
        end
    endcase
end

always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
        reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
        reg_rdata <= next_rdata;
    end else begin
        reg_rdata <= 32'h0000_0000;
    end
end

endmodule

//--- test/pint_asserts.sv
// Purpose: port-level checks of the program interrupt unit
// Assumes: one clock domain, resetn low disables every check
// Notes: override bit is shadowed from register writes
`timescale 1ns/1ps
`include "pint_map.vh"

module pint_asserts #(
    parameter ENTRY_W    = 16,
    parameter ENTRY_BASE = 16'h0100,
    parameter ENTRY_STEP = 16'h0010
) (
    // Clock, reset and register port
    input wire               sys_clk,
    input wire               resetn,
    input wire [7:0]         reg_addr,
    input wire [31:0]        reg_wdata,
    input wire               reg_wr,
    input wire               reg_rd,
    input wire [31:0]        reg_rdata,
    // Events and dispatch
    input wire               disc_par_err,
    input wire               io_par_err,
    input wire               ur_par_err,
    input wire               handler_done,
    input wire               take,
    input wire [ENTRY_W-1:0] entry_addr,
    input wire [2:0]         active_class,
    input wire               busy,
    input wire               disc_stop,
    input wire               io_stop,
    input wire               ur_stop
);
    reg ovr;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn)
            ovr <= 1'b0;
        else if (reg_wr && reg_addr == `OFS_CONTROL)
            ovr <= reg_wdata[`CTL_OVERRIDE];
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_take_single_pulse: assert property (
        take |=> !take) else $error("take held too long");
    a_take_marks_busy: assert property (
        take |-> busy && !$past(busy)) else $error("take without idle to busy");
    a_entry_per_class: assert property (
        take |-> entry_addr == ENTRY_W'(ENTRY_BASE + ENTRY_STEP * active_class))
        else $error("entry address does not match class");
    a_class_held_busy: assert property (
        busy && !take |-> $stable(active_class) && $stable(entry_addr))
        else $error("class changed while handler runs");
    a_done_frees_unit: assert property (
        busy && handler_done |=> !busy && !take) else $error("resume not taken");
    a_disc_stop_rule: assert property (
        disc_stop == ($past(disc_par_err) && !$past(ovr))) else $error("disc stop wrong");
    a_io_stop_rule: assert property (
        io_stop == ($past(io_par_err) && !$past(ovr))) else $error("io stop wrong");
    a_ur_stop_rule: assert property (
        ur_stop == ($past(ur_par_err) && !$past(ovr))) else $error("unit record stop wrong");
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
endmodule

bind program_interrupt_unit pint_asserts #(
    .ENTRY_W(ENTRY_W), .ENTRY_BASE(ENTRY_BASE), .ENTRY_STEP(ENTRY_STEP)
) chk (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .disc_par_err(disc_par_err), .io_par_err(io_par_err), .ur_par_err(ur_par_err),
    .handler_done(handler_done), .take(take), .entry_addr(entry_addr),
    .active_class(active_class), .busy(busy), .disc_stop(disc_stop),
    .io_stop(io_stop), .ur_stop(ur_stop)
);

//--- test/handler_model.sv
// Purpose: program control stand-in running one handler per take
// Assumes: hold chosen by the bench, long enough to clear toggles
// Notes: short and long holds model quick and slow handlers
`timescale 1ns/1ps

module handler_model (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       resetn,
    // Dispatch side
    input  wire       take,
    input  wire [3:0] hold,
    output reg        handler_done
);
    reg [3:0] left;
    reg       run;

    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            run <= 1'b0;
            left <= 4'h0;
            handler_done <= 1'b0;
        end else if (take) begin
            run <= 1'b1;
            left <= hold;
            handler_done <= 1'b0;
        end else if (run && left == 4'h0) begin
            run <= 1'b0;
            handler_done <= 1'b1;
        end else begin
            left <= left - 4'h1;
            handler_done <= 1'b0;
        end
    end
endmodule

//--- test/program_interrupt_unit_bench.sv
// Purpose: self-checking bench for the program interrupt unit
// Assumes: 250 MHz clock, handler model answers each take
// Notes: random events under global ignore, then ordered dispatch
`timescale 1ns/1ps
`include "pint_map.vh"

module program_interrupt_unit_bench;
    localparam EB = 16'h0200;
    localparam ES = 16'h0020;
    logic        sys_clk, resetn, reg_wr, reg_rd, xfer_valid, xfer_parity;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, rd_data;
    logic [5:0]  xfer_char;
    logic [6:0]  errs;
    logic [7:0]  evt [1:5];
    logic [7:0]  expt [0:5];
    logic [3:0]  hold;
    wire  [31:0] reg_rdata;
    wire  [15:0] entry_addr;
    wire  [2:0]  active_class;
    wire         handler_done, take, busy, disc_stop, io_stop, ur_stop;
    int          num_errors, n_tests, n_take, cyc, i, k;

    program_interrupt_unit #(.ENTRY_BASE(EB), .ENTRY_STEP(ES)) uut (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .xfer_valid(xfer_valid), .xfer_char(xfer_char), .xfer_parity(xfer_parity),
        .arith_bad_char(errs[0]), .addr_bad_char(errs[1]), .module_missing(errs[2]),
        .program_fault(errs[3]), .disc_par_err(errs[4]), .io_par_err(errs[5]),
        .ur_par_err(errs[6]), .disc_evt(evt[1]), .input_evt(evt[2]),
        .realtime_evt(evt[3]), .unitrec_evt(evt[4]), .othercpu_evt(evt[5]),
        .handler_done(handler_done), .take(take), .entry_addr(entry_addr),
        .active_class(active_class), .busy(busy), .disc_stop(disc_stop),
        .io_stop(io_stop), .ur_stop(ur_stop));
    handler_model far (.sys_clk(sys_clk), .resetn(resetn), .take(take), .hold(hold),
        .handler_done(handler_done));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) if (take === 1'b1) n_take++;
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            results;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(string w, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdc(logic [7:0] a, logic [31:0] e, string w);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(w, e, reg_rdata);
    endtask
    function automatic logic [31:0] cmd(logic [1:0] op, logic [2:0] c, logic [2:0] d);
        return (32'(op) << `CMD_OP_LO) | (32'(d) << `CMD_DETAIL_LO) | 32'(c);
    endfunction
    task automatic evt_pulse(int c, logic [7:0] b);
        @(posedge sys_clk);
        evt[c] <= b;
        expt[c] = expt[c] | b;
        @(posedge sys_clk);
        evt[c] <= 8'h00;
    endtask
    task automatic err_pulse(int j, bit ov);
        @(posedge sys_clk);
        errs[j] <= 1'b1;
        expt[0][j == 0 ? 1 : (j == 1 ? 2 : j)] = 1'b1;
        @(posedge sys_clk);
        errs <= 7'h00;
        #1 check("stops", 32'(j > 3 && !ov) << (6 - j), 32'({disc_stop, io_stop, ur_stop}));
    endtask
    task automatic xfer(logic [5:0] c, bit ok);
        @(posedge sys_clk);
        xfer_valid <= 1'b1;
        xfer_char <= c;
        xfer_parity <= ok ? ~^c : ^c;
        if (!ok) expt[0][0] = 1'b1;
        @(posedge sys_clk);
        xfer_valid <= 1'b0;
    endtask
    // Waits for a take, checks its class, clears the class, waits for resume
    task automatic serve(logic [2:0] c, bit res);
        hold <= res ? 4'hF : 4'(4 + $urandom % 8);
        k = 0;
        do begin
            @(posedge sys_clk);
            #1 k++;
        end while (take !== 1'b1 && k < 64);
        check("active_class", 32'(c), 32'(active_class));
        check("entry_addr", 32'(EB + ES * c), 32'(entry_addr));
        wr(`OFS_COMMAND, cmd(`OP_CLR_CLASS, c, 3'h0));
        expt[c] = 8'h00;
        // Slow handler: resume by command must free the unit first
        if (res) begin
            wr(`OFS_COMMAND, 32'h1 << `CMD_RESUME);
            #1 check("busy", 32'h0, 32'(busy));
        end
        #1 while (busy === 1'b1 && k < 128) begin
            @(posedge sys_clk);
            #1 k++;
        end
        check("busy", 32'h0, 32'(busy));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        resetn = 1'b0;
        {reg_wr, reg_rd, xfer_valid, xfer_parity, xfer_char, errs} = '0;
        {reg_addr, reg_wdata, hold} = '0;
        for (i = 0; i < 6; i++) expt[i] = 8'h00;
        for (i = 1; i < 6; i++) evt[i] = 8'h00;
        i = $urandom(32'h70803d65);
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdc(`OFS_CONTROL, 32'(`RST_CONTROL), "control");
        rdc(`OFS_CLASS_IGN, 32'(`RST_CLASS_IGN), "class_ign");
        rdc(`OFS_SUB_IGN, 32'(`RST_SUB_IGN), "sub_ign");
        wr(8'h1C, $urandom);
        rdc(8'h1C, 32'h0, "unmapped");
        wr(`OFS_CONTROL, 32'h1);
        xfer(6'($urandom), 1'b1);
        rdc(`OFS_DETAIL_BASE, 32'h0, "good parity");
        xfer(6'($urandom), 1'b0);
        for (i = 0; i < 10; i++) begin
            if (i == 7) wr(`OFS_CONTROL, 32'h3);
            err_pulse(i < 7 ? i : i - 3, i > 6);
        end
        for (i = 1; i < 6; i++) evt_pulse(i, 8'h01);
        for (i = 0; i < 40; i++) evt_pulse(1 + $urandom % 5, 8'($urandom));
        fork
            wr(`OFS_COMMAND, cmd(`OP_CLR_ONE, 3'h3, 3'h2));
            evt_pulse(3, 8'h04);
        join
        wr(`OFS_COMMAND, cmd(`OP_SET_ONE, 3'h5, 3'h7));
        expt[5][7] = 1'b1;
        wr(`OFS_COMMAND, cmd(`OP_CLR_ONE, 3'h2, 3'h7));
        expt[2][7] = 1'b0;
        for (i = 0; i < 6; i++) rdc(`OFS_DETAIL_BASE + 8'(4 * i), 32'(expt[i]), "detail");
        rdc(`OFS_STATUS, 32'h0, "status global");
        wr(`OFS_SUB_IGN, 32'h3);
        wr(`OFS_CLASS_IGN, 32'h3E);
        wr(`OFS_CONTROL, 32'h2);
        rdc(`OFS_STATUS, 32'h0, "status subclass");
        check("takes", 32'h0, 32'(n_take));
        wr(`OFS_SUB_IGN, 32'h1);
        serve(3'h0, 1'b0);
        err_pulse(3, 1'b1);
        err_pulse(2, 1'b1);
        rdc(`OFS_DETAIL_BASE, 32'(expt[0]), "module missing");
        wr(`OFS_CONTROL, 32'h3);
        wr(`OFS_SUB_IGN, 32'h0);
        wr(`OFS_CLASS_IGN, 32'h0);
        rdc(`OFS_STATUS, 32'h0, "status global");
        wr(`OFS_CONTROL, 32'h2);
        for (i = 0; i < 6; i++) serve(3'(i), 1'b0);
        check("takes", 32'h7, 32'(n_take));
        rdc(`OFS_STATUS, 32'(`CLS_OTHERCPU) << `STS_CLASS_LO, "status idle");
        wr(`OFS_COMMAND, cmd(`OP_SET_ONE, 3'h4, 3'h1));
        expt[4][1] = 1'b1;
        serve(3'h4, 1'b1);
        check("takes", 32'h8, 32'(n_take));
        results;
    end
endmodule
